// ==== byte_fifo.sv ====
// Purpose: Small flip-flop FIFO of bytes with an occupancy count.
// Assumes: Nothing of the caller at full; writes beyond full are refused inside the FIFO.
// Notes: Clear empties the FIFO in one cycle.
`timescale 1ns/1ns
module byte_fifo #(
  parameter int DEPTH = 128,
  parameter int CW = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  output logic [CW-1:0] count
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || CW <= AW) begin
      $error("byte_fifo depth must be a power of two above one");
    end
  end

  logic [7:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic do_wr;
  logic do_rd;

  assign do_wr = wr_en && (count < CW'(DEPTH));
  assign do_rd = rd_en && (count != '0);
  assign rd_data = mem_reg[rd_ptr_reg];

  always_ff @(posedge ref_clk) begin
    if (do_wr) begin
      mem_reg[wr_ptr_reg] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || clear) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (do_rd) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      if (do_wr && !do_rd) begin
        count <= count + CW'(1);
      end else if (do_rd && !do_wr) begin
        count <= count - CW'(1);
      end
    end
  end
endmodule // byte_fifo

// ==== coupler_model.sv ====
// Purpose: Coupler side that relays the controller's process image to the block.
// Assumes: One exchange at a time; the answer is taken one edge after the strobe.
// Notes: Control and data stand until the next exchange; only the strobe drops.
`timescale 1ns/1ns
module coupler_model (
  input wire logic ref_clk,
  input wire logic [7:0] stat_byte,
  input wire logic [47:0] in_data,
  output logic cyc_valid,
  output logic [7:0] ctrl_byte,
  output logic [39:0] out_data
);
  initial begin
    cyc_valid = 1'b0;
    ctrl_byte = 8'h00;
    out_data = 40'h0;
  end
  task automatic xfer(input logic [7:0] ctl, input logic [39:0] d,
      output logic [7:0] st, output logic [47:0] din);
    @(posedge ref_clk);
    ctrl_byte <= ctl;
    out_data <= d;
    cyc_valid <= 1'b1;
    @(posedge ref_clk);
    cyc_valid <= 1'b0;
    #1;
    st = stat_byte;
    din = in_data;
  endtask
endmodule // coupler_model

// ==== handshake_monitor.sv ====
// Purpose: Concurrent checks on the ports of the process-image handshake.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: Attached by bind from the bench top; status is judged one edge after a request.
`timescale 1ns/1ns
module handshake_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cyc_valid,
  input wire logic [7:0] ctrl_byte,
  input wire logic [7:0] stat_byte,
  input wire logic [2:0] mapped_count,
  input wire logic line_tx_ready,
  input wire logic line_tx_valid,
  input wire logic [7:0] line_tx_data,
  input wire logic line_enable
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Register mode and status framing
  // ----------------------------------------------------------------
  reg_echo_a: assert property (
    cyc_valid && ctrl_byte[7] |=> stat_byte == {2'b10, $past(ctrl_byte[5:0])})
    else $error("Status byte does not echo the register address.");
  proc_mode_a: assert property (
    cyc_valid && !ctrl_byte[7] |=> !stat_byte[7])
    else $error("Status byte shows register mode after a process exchange.");
  stat_hold_a: assert property (
    !cyc_valid |=> $stable(stat_byte))
    else $error("Status byte changed without an exchange.");
  mapped_range_a: assert property (
    mapped_count >= 3'h1 && mapped_count <= 3'h5)
    else $error("Mapped byte count left the range one to five.");
  // ----------------------------------------------------------------
  // Handshakes
  // ----------------------------------------------------------------
  tx_ack_a: assert property (
    $changed(stat_byte[0]) && !stat_byte[7] && !$past(stat_byte[7])
      |-> stat_byte[0] == $past(ctrl_byte[0]))
    else $error("Transmit acknowledge moved away from the request.");
  rx_len_a: assert property (
    $changed(stat_byte[1]) && !stat_byte[7] && !$past(stat_byte[7])
      |-> stat_byte[6:4] != 3'h0)
    else $error("Receive request toggled with an empty length.");
  init_off_a: assert property (
    cyc_valid && !ctrl_byte[7] && ctrl_byte[2] |-> ##[1:2] !line_enable)
    else $error("Line stayed enabled under an init request.");
  init_ack_a: assert property (
    $rose(stat_byte[2]) && !stat_byte[7] |-> $past(ctrl_byte[2]) && !$past(ctrl_byte[7]))
    else $error("Init acknowledge rose without an init request.");
  tx_hold_a: assert property (
    line_tx_valid && !line_tx_ready |=> line_tx_valid && $stable(line_tx_data))
    else $error("Line byte dropped or changed while stalled.");
  reg_wr_c: cover property (cyc_valid && ctrl_byte[7] && ctrl_byte[6]);
  tx_ack_c: cover property ($changed(stat_byte[0]) && !stat_byte[7]);
  init_ack_c: cover property ($rose(stat_byte[2]) && !stat_byte[7]);
endmodule // handshake_monitor

// ==== handshake_pkg.sv ====
// Purpose: Shared constants for the process-image handshake of a serial terminal.
// Assumes: One 10 MHz clock, synchronous active-high reset.
// Notes: Register indices are the six-bit addresses carried in the control byte.
package handshake_pkg;

  localparam logic [5:0] ADDR_TX_COUNT = 6'h00;
  localparam logic [5:0] ADDR_RX_COUNT = 6'h01;
  localparam logic [5:0] ADDR_DIAG = 6'h06;
  localparam logic [5:0] ADDR_FULL_THRESHOLD = 6'h12;
  localparam logic [5:0] ADDR_LINE_BAUD = 6'h20;
  localparam logic [5:0] ADDR_LINE_FRAME = 6'h21;
  localparam logic [5:0] ADDR_LINE_FEATURE = 6'h22;
  localparam logic [5:0] ADDR_MAPPED_COUNT = 6'h23;

  localparam logic [15:0] RST_FULL_THRESHOLD = 16'h0080;
  localparam logic [15:0] RST_LINE_BAUD = 16'h0006;
  localparam logic [15:0] RST_LINE_FRAME = 16'h0003;
  localparam logic [15:0] RST_LINE_FEATURE = 16'h0002;
  localparam logic [15:0] RST_MAPPED_COUNT = 16'h0003;

  localparam int CTL_REG_MODE = 7;
  localparam int CTL_WRITE = 6;
  localparam int CTL_INIT = 2;
  localparam int CTL_RX_ACK = 1;
  localparam int CTL_TX_REQ = 0;
  localparam int LEN_LSB = 4;

  localparam int DIAG_OVERFLOW = 0;
  localparam int DIAG_PARITY = 1;
  localparam int DIAG_FRAMING = 2;
  localparam int DIAG_OVERRUN = 3;
  localparam int DIAG_FULL = 4;

  localparam int MAX_DATA_BYTES = 5;
  localparam int INIT_CYCLES = 4;

endpackage

// ==== process_handshake.sv ====
// Purpose: Process-image side of a serial terminal: register mode and handshakes.
// Assumes: A new control byte and output data arrive with cyc_valid each exchange.
// Notes: Serial framing lives elsewhere; the line side is a plain byte stream here.
`timescale 1ns/1ns
module process_handshake
  import handshake_pkg::*;
#(
  parameter int RX_DEPTH = 128,
  parameter int TX_DEPTH = 128
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cyc_valid,
  input wire logic [7:0] ctrl_byte,
  input wire logic [39:0] out_data,
  input wire logic word_align,
  output logic [7:0] stat_byte,
  output logic [47:0] in_data,
  output logic [2:0] mapped_count,
  input wire logic line_rx_valid,
  input wire logic [7:0] line_rx_data,
  input wire logic line_parity_err,
  input wire logic line_framing_err,
  input wire logic line_overrun_err,
  input wire logic line_tx_ready,
  output logic line_tx_valid,
  output logic [7:0] line_tx_data,
  output logic line_enable,
  output logic [15:0] line_baud,
  output logic [15:0] line_frame,
  output logic [15:0] line_feature
);

  initial begin
    if (RX_DEPTH > 255 || TX_DEPTH > 255) begin
      $error("process_handshake fifo depth must fit an eight-bit count");
    end
  end

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_INIT = 2'b01,
    ST_INIT_DONE = 2'b10
  } init_state_t;

  init_state_t init_state_reg;
  logic [15:0] mapped_reg;
  logic [15:0] threshold_reg;
  logic [15:0] baud_reg;
  logic [15:0] frame_reg;
  logic [15:0] feature_reg;
  logic [7:0] diag_reg;
  logic [7:0] full_level_reg;
  logic [2:0] init_cnt_reg;
  logic tx_req_seen_reg;
  logic rx_ack_seen_reg;
  logic tx_accepted_reg;
  logic rx_request_reg;
  logic rx_pending_reg;
  logic [2:0] in_len_reg;
  logic [7:0] rx_copy_reg [MAX_DATA_BYTES];
  logic [2:0] tx_left_reg;
  logic [2:0] tx_idx_reg;
  logic [39:0] tx_hold_reg;
  logic [2:0] rx_take_reg;
  logic [2:0] rx_fill_reg;

  logic [7:0] rx_count;
  logic [7:0] tx_count;
  logic [7:0] rx_head;
  logic [7:0] tx_head;
  logic running;
  logic rx_full;
  logic rx_good;
  logic rx_err;
  logic reg_mode;
  logic [5:0] reg_addr_field;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic tx_edge;
  logic rx_ack_edge;
  logic [2:0] mapped_clamped;
  logic [2:0] out_len;
  logic rx_pop;
  logic tx_push;
  logic fifo_clear;

  // Clamp a length field to the mapped byte count.
  function automatic logic [2:0] clamp_len(input logic [2:0] len, input logic [2:0] lim);
    clamp_len = (len > lim) ? lim : len;
  endfunction

  assign running = (init_state_reg == ST_RUN);
  assign fifo_clear = !running;
  assign reg_mode = cyc_valid && ctrl_byte[CTL_REG_MODE];
  assign reg_addr_field = ctrl_byte[5:0];
  // Padding byte moves the value one byte up when aligning to words.
  assign reg_wdata = word_align ? {out_data[15:8], out_data[23:16]}
                                : {out_data[7:0], out_data[15:8]};
  assign mapped_clamped = (mapped_reg[7:0] == 8'h00) ? 3'd1 :
                          (mapped_reg[7:0] > 8'h05) ? 3'd5 : mapped_reg[2:0];
  assign out_len = clamp_len(ctrl_byte[6:4], mapped_clamped);
  // The threshold takes effect only after an init, like the other line settings.
  assign rx_full = (rx_count >= full_level_reg) || (rx_count == 8'(RX_DEPTH));
  assign rx_err = line_rx_valid && (line_parity_err || line_framing_err || line_overrun_err);
  assign rx_good = line_rx_valid && !rx_err && !rx_full && running;
  // changes seen against the last control byte in process-data mode.
  assign tx_edge = cyc_valid && !ctrl_byte[CTL_REG_MODE] && running
                   && (ctrl_byte[CTL_TX_REQ] != tx_req_seen_reg);
  assign rx_ack_edge = cyc_valid && !ctrl_byte[CTL_REG_MODE]
                       && (ctrl_byte[CTL_RX_ACK] != rx_ack_seen_reg);
  assign tx_push = (tx_left_reg != 3'd0);
  assign rx_pop = (rx_take_reg != 3'd0);

  always_comb begin
    case (reg_addr_field)
      ADDR_TX_COUNT: reg_rdata = {8'h00, tx_count};
      ADDR_RX_COUNT: reg_rdata = {8'h00, rx_count};
      ADDR_DIAG: reg_rdata = {8'h00, diag_reg};
      ADDR_FULL_THRESHOLD: reg_rdata = threshold_reg;
      ADDR_LINE_BAUD: reg_rdata = baud_reg;
      ADDR_LINE_FRAME: reg_rdata = frame_reg;
      ADDR_LINE_FEATURE: reg_rdata = feature_reg;
      ADDR_MAPPED_COUNT: reg_rdata = mapped_reg;
      default: reg_rdata = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------
  // FIFOs
  // ----------------------------------------------------------------
  byte_fifo #(.DEPTH(RX_DEPTH), .CW(8)) rx_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .clear(fifo_clear),
    .wr_en(rx_good),
    .wr_data(line_rx_data),
    .rd_en(rx_pop),
    .rd_data(rx_head),
    .count(rx_count)
  );

  byte_fifo #(.DEPTH(TX_DEPTH), .CW(8)) tx_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .clear(fifo_clear),
    .wr_en(tx_push),
    .wr_data(tx_hold_reg[8*tx_idx_reg +: 8]),
    .rd_en(line_tx_valid && line_tx_ready),
    .rd_data(tx_head),
    .count(tx_count)
  );

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mapped_reg <= RST_MAPPED_COUNT;
      threshold_reg <= RST_FULL_THRESHOLD;
      baud_reg <= RST_LINE_BAUD;
      frame_reg <= RST_LINE_FRAME;
      feature_reg <= RST_LINE_FEATURE;
    end else if (reg_mode && ctrl_byte[CTL_WRITE]) begin
      case (reg_addr_field)
        ADDR_FULL_THRESHOLD: threshold_reg <= reg_wdata;
        ADDR_LINE_BAUD: baud_reg <= reg_wdata;
        ADDR_LINE_FRAME: frame_reg <= reg_wdata;
        ADDR_LINE_FEATURE: feature_reg <= reg_wdata;
        ADDR_MAPPED_COUNT: mapped_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Diagnostics
  // ----------------------------------------------------------------
  // Error bits are sticky and only reset or init clears them, since no software clear is defined; the full bit follows rx_full.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      diag_reg <= 8'h00;
    end else if (init_state_reg == ST_INIT) begin
      diag_reg <= 8'h00;
    end else begin
      if (line_rx_valid && !rx_err && rx_full) begin
        diag_reg[DIAG_OVERFLOW] <= 1'b1;
      end
      if (line_rx_valid && line_parity_err) begin
        diag_reg[DIAG_PARITY] <= 1'b1;
      end
      if (line_rx_valid && line_framing_err) begin
        diag_reg[DIAG_FRAMING] <= 1'b1;
      end
      if (line_rx_valid && line_overrun_err) begin
        diag_reg[DIAG_OVERRUN] <= 1'b1;
      end
      diag_reg[DIAG_FULL] <= rx_full;
    end
  end

  // ----------------------------------------------------------------
  // Initialization
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      init_state_reg <= ST_RUN;
      init_cnt_reg <= 3'd0;
      full_level_reg <= RST_FULL_THRESHOLD[7:0];
    end else begin
      case (init_state_reg)
        ST_RUN: begin
          if (cyc_valid && !ctrl_byte[CTL_REG_MODE] && ctrl_byte[CTL_INIT]) begin
            init_state_reg <= ST_INIT;
            init_cnt_reg <= 3'd0;
          end
        end
        ST_INIT: begin
          full_level_reg <= threshold_reg[7:0];
          if (init_cnt_reg == 3'(INIT_CYCLES - 1)) begin
            init_state_reg <= ST_INIT_DONE;
          end else begin
            init_cnt_reg <= init_cnt_reg + 3'd1;
          end
        end
        ST_INIT_DONE: begin
          if (cyc_valid && !ctrl_byte[CTL_REG_MODE] && !ctrl_byte[CTL_INIT]) begin
            init_state_reg <= ST_RUN;
          end
        end
        default: init_state_reg <= ST_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Transmit handshake
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_req_seen_reg <= 1'b0;
      tx_accepted_reg <= 1'b0;
      tx_left_reg <= 3'd0;
      tx_idx_reg <= 3'd0;
      tx_hold_reg <= 40'h0;
    end else if (!running) begin
      tx_left_reg <= 3'd0;
      if (cyc_valid && !ctrl_byte[CTL_REG_MODE]) begin
        tx_req_seen_reg <= ctrl_byte[CTL_TX_REQ];
        tx_accepted_reg <= ctrl_byte[CTL_TX_REQ];
      end
    end else if (tx_edge && tx_left_reg == 3'd0) begin
      tx_req_seen_reg <= ctrl_byte[CTL_TX_REQ];
      tx_hold_reg <= out_data;
      tx_idx_reg <= 3'd0;
      tx_left_reg <= out_len;
      if (out_len == 3'd0) begin
        tx_accepted_reg <= ctrl_byte[CTL_TX_REQ];
      end
    end else if (tx_push) begin
      tx_idx_reg <= tx_idx_reg + 3'd1;
      tx_left_reg <= tx_left_reg - 3'd1;
      if (tx_left_reg == 3'd1) begin
        tx_accepted_reg <= tx_req_seen_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive handshake
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_ack_seen_reg <= 1'b0;
      rx_request_reg <= 1'b0;
      rx_pending_reg <= 1'b0;
      in_len_reg <= 3'd0;
      rx_take_reg <= 3'd0;
      rx_fill_reg <= 3'd0;
    end else begin
      if (rx_ack_edge) begin
        rx_ack_seen_reg <= ctrl_byte[CTL_RX_ACK];
        if (ctrl_byte[CTL_RX_ACK] == rx_request_reg) begin
          rx_pending_reg <= 1'b0;
        end
      end
      if (!running) begin
        rx_take_reg <= 3'd0;
      end else if (!rx_pending_reg && rx_take_reg == 3'd0 && rx_count != 8'h00) begin
        rx_take_reg <= (rx_count > 8'(mapped_clamped)) ? mapped_clamped : rx_count[2:0];
        rx_fill_reg <= 3'd0;
        rx_pending_reg <= 1'b1;
      end else if (rx_pop) begin
        rx_copy_reg[rx_fill_reg] <= rx_head;
        rx_fill_reg <= rx_fill_reg + 3'd1;
        rx_take_reg <= rx_take_reg - 3'd1;
        if (rx_take_reg == 3'd1) begin
          in_len_reg <= rx_fill_reg + 3'd1;
          rx_request_reg <= !rx_request_reg;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Process image outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stat_byte <= 8'h00;
      in_data <= 48'h0;
    end else if (reg_mode) begin
      stat_byte <= {1'b1, 1'b0, reg_addr_field};
      if (ctrl_byte[CTL_WRITE]) begin
        in_data <= 48'h0;
      end else if (word_align) begin
        in_data <= {24'h0, reg_rdata[7:0], reg_rdata[15:8], 8'h00};
      end else begin
        in_data <= {32'h0, reg_rdata[7:0], reg_rdata[15:8]};
      end
    end else if (cyc_valid) begin
      stat_byte <= {1'b0, in_len_reg, diag_reg[DIAG_FULL], init_state_reg == ST_INIT_DONE,
                    rx_request_reg, tx_accepted_reg};
      in_data <= {8'h00, rx_copy_reg[4], rx_copy_reg[3], rx_copy_reg[2],
                  rx_copy_reg[1], rx_copy_reg[0]};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mapped_count <= RST_MAPPED_COUNT[2:0];
      line_tx_valid <= 1'b0;
      line_tx_data <= 8'h00;
      line_enable <= 1'b0;
      line_baud <= RST_LINE_BAUD;
      line_frame <= RST_LINE_FRAME;
      line_feature <= RST_LINE_FEATURE;
    end else begin
      mapped_count <= mapped_clamped;
      line_enable <= running;
      if (line_tx_valid && line_tx_ready) begin
        line_tx_valid <= 1'b0;
      end else if (!line_tx_valid && running && tx_count != 8'h00) begin
        line_tx_valid <= 1'b1;
        line_tx_data <= tx_head;
      end
      if (init_state_reg == ST_INIT) begin
        line_baud <= baud_reg;
        line_frame <= frame_reg;
        line_feature <= feature_reg;
      end
    end
  end

endmodule // process_handshake

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the process-image handshake.
// Assumes: 10 MHz clock, reset held two cycles, small FIFO depths.
// Notes: Line side is driven here; the coupler model carries the exchanges.
`timescale 1ns/1ns
module tb_top;
  import handshake_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cyc_valid, word_align, line_rx_valid, line_tx_ready, line_tx_valid, line_enable;
  logic line_parity_err, line_framing_err, line_overrun_err;
  logic [7:0] ctrl_byte, stat_byte, line_rx_data, line_tx_data, st;
  logic [39:0] out_data, d;
  logic [47:0] in_data, din;
  logic [2:0] mapped_count;
  logic [15:0] line_baud, line_frame, line_feature, v;
  logic [7:0] txq[$];
  logic tx_bit, ack_bit, init_bit, wa;
  int n_mismatch, cmp_count, len, n, k;
  always #50 ref_clk = ~ref_clk;
  process_handshake #(.RX_DEPTH(8), .TX_DEPTH(16)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .cyc_valid(cyc_valid), .ctrl_byte(ctrl_byte),
    .out_data(out_data), .word_align(word_align), .stat_byte(stat_byte),
    .in_data(in_data), .mapped_count(mapped_count), .line_rx_valid(line_rx_valid),
    .line_rx_data(line_rx_data), .line_parity_err(line_parity_err),
    .line_framing_err(line_framing_err), .line_overrun_err(line_overrun_err),
    .line_tx_ready(line_tx_ready), .line_tx_valid(line_tx_valid),
    .line_tx_data(line_tx_data), .line_enable(line_enable), .line_baud(line_baud),
    .line_frame(line_frame), .line_feature(line_feature));
  coupler_model i_cpl (
    .ref_clk(ref_clk), .stat_byte(stat_byte), .in_data(in_data),
    .cyc_valid(cyc_valid), .ctrl_byte(ctrl_byte), .out_data(out_data));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected byte at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] pctl(input logic [2:0] l);
    return {1'b0, l, 1'b0, init_bit, ack_bit, tx_bit};
  endfunction
  function automatic logic [15:0] rd_val(input logic [47:0] x);
    return wa ? {x[15:8], x[23:16]} : {x[7:0], x[15:8]};
  endfunction
  task automatic reg_rd(input logic [5:0] a, input logic [15:0] exp);
    i_cpl.xfer({2'b10, a}, 40'({$urandom, $urandom}), st, din);
    chk_byte(st, {2'b10, a});
    chk_word(rd_val(din), exp);
  endtask
  task automatic reg_wr(input logic [5:0] a, input logic [15:0] val);
    d = 40'({$urandom, $urandom});
    if (wa) d[23:8] = {val[7:0], val[15:8]};
    else d[15:0] = {val[7:0], val[15:8]};
    i_cpl.xfer({2'b11, a}, d, st, din);
    chk_byte(st, {2'b10, a});
  endtask
  // Unused data lines carry the inverse of the last character, never a stale copy.
  task automatic send_char(input logic [7:0] c, input int e);
    @(posedge ref_clk);
    line_rx_valid <= 1'b1;
    line_rx_data <= c;
    line_parity_err <= (e == 1);
    line_framing_err <= (e == 2);
    line_overrun_err <= (e == 3);
    @(posedge ref_clk);
    line_rx_valid <= 1'b0;
    line_rx_data <= ~c;
    {line_parity_err, line_framing_err, line_overrun_err} <= 3'h0;
  endtask
  task automatic rx_poll();
    for (k = 0; k < 6; k++) begin
      i_cpl.xfer(pctl(3'h0), 40'({$urandom, $urandom}), st, din);
      if (st[1] !== ack_bit) break;
    end
  endtask
  always @(posedge ref_clk) begin
    line_tx_ready <= ($urandom_range(3) != 0);
    if (line_tx_valid && line_tx_ready) txq.push_back(line_tx_data);
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    stop_test();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h0d8f6df6));
    {line_rx_valid, line_parity_err, line_framing_err, line_overrun_err} = 4'h0;
    line_rx_data = 8'h00;
    word_align = 1'b0;
    {wa, tx_bit, ack_bit, init_bit} = 4'h0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk_byte({5'h0, mapped_count}, 8'h03);
    chk_word(line_baud ^ line_frame ^ line_feature, 16'h0007);
    reg_rd(6'h23, 16'h0003);
    reg_rd(6'h12, 16'h0080);
    reg_rd(6'h3f, 16'h0000);
    @(posedge ref_clk) word_align <= 1'b1;
    wa = 1'b1;
    reg_rd(6'h23, 16'h0003);
    @(posedge ref_clk) word_align <= 1'b0;
    wa = 1'b0;
    reg_wr(6'h23, 16'h0005);
    reg_rd(6'h23, 16'h0005);
    chk_byte({5'h0, mapped_count}, 8'h05);
    reg_wr(6'h06, 16'h00ff);
    reg_rd(6'h06, 16'h0000);
    i_cpl.xfer(pctl(3'h0), 40'h0, st, din);
    repeat (10) @(posedge ref_clk);
    txq.delete();
    for (n = 0; n < 5; n++) begin
      len = (n == 0) ? 5 : (n == 1) ? 7 : $urandom_range(1, 5);
      d = 40'({$urandom, $urandom});
      tx_bit = ~tx_bit;
      i_cpl.xfer(pctl(len[2:0]), d, st, din);
      repeat (8) @(posedge ref_clk);
      i_cpl.xfer(pctl(len[2:0]), d, st, din);
      chk_byte({7'h0, st[0]}, {7'h0, tx_bit});
      if (len > 5) len = 5;
      for (k = 0; k < 200 && txq.size() < len; k++) @(posedge ref_clk);
      repeat (4) @(posedge ref_clk);
      chk_byte(8'(txq.size()), 8'(len));
      for (k = 0; k < len; k++) chk_byte(txq[k], d[8*k+:8]);
      txq.delete();
    end
    reg_rd(6'h00, 16'h0000);
    send_char(8'h41, 0);
    send_char(8'h42, 1);
    send_char(8'h43, 2);
    send_char(8'h44, 3);
    send_char(8'h45, 0);
    // The first character is handed over alone; the rest wait for the acknowledge.
    rx_poll();
    chk_byte({5'h0, st[6:4]}, 8'h01);
    chk_byte(din[7:0], 8'h41);
    send_char(8'h46, 0);
    repeat (4) @(posedge ref_clk);
    i_cpl.xfer(pctl(3'h0), 40'h0, st, din);
    chk_byte({5'h0, st[6:4]}, 8'h01);
    chk_byte(din[7:0], 8'h41);
    ack_bit = st[1];
    rx_poll();
    chk_byte({5'h0, st[6:4]}, 8'h02);
    chk_word(din[15:0], 16'h4645);
    ack_bit = st[1];
    i_cpl.xfer(pctl(3'h0), 40'h0, st, din);
    reg_rd(6'h06, 16'h000e);
    reg_wr(6'h12, 16'h0004);
    reg_wr(6'h20, 16'h0007);
    chk_word(line_baud, 16'h0006);
    init_bit = 1'b1;
    i_cpl.xfer(pctl(3'h0), 40'h0, st, din);
    repeat (6) @(posedge ref_clk);
    i_cpl.xfer(pctl(3'h0), 40'h0, st, din);
    chk_byte({7'h0, st[2]}, 8'h01);
    chk_byte({7'h0, line_enable}, 8'h00);
    chk_word(line_baud, 16'h0007);
    init_bit = 1'b0;
    i_cpl.xfer(pctl(3'h0), 40'h0, st, din);
    i_cpl.xfer(pctl(3'h0), 40'h0, st, din);
    chk_byte({7'h0, st[2]}, 8'h00);
    reg_rd(6'h06, 16'h0000);
    chk_byte({5'h0, mapped_count}, 8'h05);
    // One character leaves at once for the controller, so five leave four queued.
    for (n = 0; n < 5; n++) send_char(n[7:0], 0);
    reg_rd(6'h06, 16'h0010);
    send_char(8'h55, 0);
    reg_rd(6'h06, 16'h0011);
    reg_rd(6'h01, 16'h0004);
    for (n = 0; n < 4; n++) begin
      v = {8'h00, 8'($urandom_range(255))};
      reg_wr(6'h12, v);
      reg_rd(6'h12, v);
    end
    stop_test();
  end
endmodule // tb_top

bind process_handshake handshake_monitor i_mon (
  .ref_clk(ref_clk), .rst(rst), .cyc_valid(cyc_valid), .ctrl_byte(ctrl_byte),
  .stat_byte(stat_byte), .mapped_count(mapped_count), .line_tx_ready(line_tx_ready),
  .line_tx_valid(line_tx_valid), .line_tx_data(line_tx_data), .line_enable(line_enable));
